// ===== rtl/ippc_top.sv
// ippc_top: pending state, priority selection and arbitration for 32
// interrupt sources, registers over AXI4-Lite
// assumes: irq_req synchronous to aclk; core_ack/core_ret one-cycle pulses
//
// Functional notes
// - writing one to set register pends source
// - writing one to clear register unpends source
// - set register reads back pending state
// - clear register reads pending; reset clears all
// - thirty-two priority selects packed from 0x40
// - only bits 7:6 writable, others read zero
// - default priority n; lower value wins
// - effective priority is n plus field times 64
// - read-only bit writes ignored, no error
// - level while inactive or rising edge pends
// - ack makes active; level re-pends on return
// - enable gates forwarding; enabling asserted request pends
// - best priority first; better one preempts, nests
`include "ippc_defines.svh"

module ippc_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  // axi4-lite write data
  input  wire logic        wvalid,
  output      logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // axi4-lite write response
  output      logic        bvalid,
  input  wire logic        bready,
  output      logic [1:0]  bresp,
  // axi4-lite read address
  input  wire logic        arvalid,
  output      logic        arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  // axi4-lite read data
  output      logic        rvalid,
  input  wire logic        rready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  // peripheral requests
  input  wire logic [31:0] irq_req,
  // processor core
  output      logic        core_irq,
  output      logic [4:0]  core_vec,
  input  wire logic        core_ack,
  input  wire logic        core_ret,
  // event interrupt
  output      logic        irq_out
);

  ippc_pkg::ippc_state_t s;
  ippc_pkg::ippc_state_t next_s;

  logic        do_wr;
  logic        rd_take;
  logic [31:0] wmask;
  logic [31:0] sw_set;
  logic [31:0] sw_clr;
  logic [31:0] hw_set;
  logic [31:0] ack_oh;
  logic [31:0] ret_oh;
  logic [1:0]  ev;
  logic [1:0]  ev_clr;
  logic [63:0] sel_flat;
  logic [31:0] mem_rdata;
  logic        p_found;
  logic [4:0]  p_idx;
  logic [7:0]  p_prio;
  logic        a_found;
  logic [4:0]  a_idx;
  logic [7:0]  a_prio;

  //--------------------------------------------------------------------
  // bus handshakes
  //--------------------------------------------------------------------
  assign awready = (s.wr_st == ippc_pkg::WS_IDLE) && !s.aw_got;
  assign wready  = (s.wr_st == ippc_pkg::WS_IDLE) && !s.w_got;
  assign bvalid  = (s.wr_st == ippc_pkg::WS_RESP);
  assign bresp   = s.bresp;
  assign arready = (s.rd_st == ippc_pkg::RS_IDLE);
  assign rvalid  = (s.rd_st == ippc_pkg::RS_DATA);
  assign rresp   = s.rresp;
  assign rdata   = s.rd_prio ? mem_rdata : s.rdata;
  assign do_wr   = (s.wr_st == ippc_pkg::WS_IDLE) && s.aw_got && s.w_got;
  assign rd_take = arvalid && arready;
  assign wmask   = ippc_pkg::strb_mask(s.wstrb);

  //--------------------------------------------------------------------
  // priority storage and arbiters
  //--------------------------------------------------------------------
  ippc_prio_mem u_mem (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wr_en    (do_wr && ippc_pkg::is_prio(s.awaddr)),
    .wr_idx   (s.awaddr[4:2]),
    .wr_strb  (s.wstrb),
    .wr_data  (s.wdata),
    .rd_en    (rd_take && ippc_pkg::is_prio(araddr)),
    .rd_idx   (araddr[4:2]),
    .rd_data  (mem_rdata),
    .sel_flat (sel_flat)
  );

  ippc_arbiter u_arb_pend (
    .cand     (s.pending & s.enable),
    .sel_flat (sel_flat),
    .found    (p_found),
    .idx      (p_idx),
    .prio     (p_prio)
  );

  ippc_arbiter u_arb_act (
    .cand     (s.active),
    .sel_flat (sel_flat),
    .found    (a_found),
    .idx      (a_idx),
    .prio     (a_prio)
  );

  //--------------------------------------------------------------------
  // pending and active state
  //--------------------------------------------------------------------
  always_comb
  begin
    sw_set = '0;
    sw_clr = '0;
    ev_clr = '0;
    if (do_wr && s.awaddr == `IPPC_OFS_PSET)
    begin
      sw_set = s.wdata & wmask;
    end
    if (do_wr && s.awaddr == `IPPC_OFS_PCLR)
    begin
      sw_clr = s.wdata & wmask;
    end
    if (do_wr && s.awaddr == `IPPC_OFS_EVT_STAT && s.wstrb[0])
    begin
      ev_clr = s.wdata[1:0];
    end
    ack_oh = '0;
    if (core_ack && s.core_irq && s.pending[s.core_vec])
    begin
      ack_oh[s.core_vec] = 1'b1;
    end
    ret_oh = '0;
    if (core_ret && a_found)
    begin
      ret_oh[a_idx] = 1'b1;
    end
    // level while not active, or a fresh rising edge, pends
    hw_set = s.enable & irq_req
           & ((~s.active & ~ack_oh) | ~s.req_q);
    ev = '0;
    ev[`IPPC_EVT_PEND] = |(hw_set & ~s.pending);
    ev[`IPPC_EVT_NEST] = core_ack && s.core_irq && a_found;
  end

  //--------------------------------------------------------------------
  // next state
  //--------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    // write channel
    if (awvalid && awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    case (s.wr_st)
      ippc_pkg::WS_IDLE:
      begin
        if (do_wr)
        begin
          // read-only bits simply drop, still answered okay
          next_s.bresp = ippc_pkg::addr_ok(s.awaddr) ? `IPPC_RESP_OKAY
                                                     : `IPPC_RESP_SLVERR;
          next_s.wr_st = ippc_pkg::WS_RESP;
        end
      end
      ippc_pkg::WS_RESP:
      begin
        if (bready)
        begin
          next_s.wr_st  = ippc_pkg::WS_IDLE;
          next_s.aw_got = 1'b0;
          next_s.w_got  = 1'b0;
        end
      end
      default:
      begin
        next_s.wr_st = ippc_pkg::WS_IDLE;
      end
    endcase
    if (do_wr && s.awaddr == `IPPC_OFS_ENABLE)
    begin
      next_s.enable = (s.enable & ~wmask) | (s.wdata & wmask);
    end
    if (do_wr && s.awaddr == `IPPC_OFS_EVT_MASK && s.wstrb[0])
    begin
      next_s.evt_mask = s.wdata[1:0];
    end
    // read channel
    case (s.rd_st)
      ippc_pkg::RS_IDLE:
      begin
        if (rd_take)
        begin
          next_s.rd_st   = ippc_pkg::RS_DATA;
          next_s.rd_prio = ippc_pkg::is_prio(araddr);
          next_s.rresp   = ippc_pkg::addr_ok(araddr) ? `IPPC_RESP_OKAY
                                                     : `IPPC_RESP_SLVERR;
          case (araddr)
            `IPPC_OFS_ENABLE:   next_s.rdata = s.enable;
            `IPPC_OFS_PSET:     next_s.rdata = s.pending;
            `IPPC_OFS_PCLR:     next_s.rdata = s.pending;
            `IPPC_OFS_EVT_STAT: next_s.rdata = {30'h0, s.evt};
            `IPPC_OFS_EVT_MASK: next_s.rdata = {30'h0, s.evt_mask};
            default:            next_s.rdata = `IPPC_RST_WORD;
          endcase
        end
      end
      ippc_pkg::RS_DATA:
      begin
        if (rready)
        begin
          next_s.rd_st = ippc_pkg::RS_IDLE;
        end
      end
      default:
      begin
        next_s.rd_st = ippc_pkg::RS_IDLE;
      end
    endcase
    // interrupt state; sets win over clears
    next_s.pending  = (s.pending & ~sw_clr & ~ack_oh)
                    | sw_set | hw_set;
    next_s.active   = (s.active | ack_oh) & ~ret_oh;
    next_s.req_q    = irq_req;
    // forward only a winner that beats the routine in service
    next_s.core_irq = p_found && (!a_found || p_prio < a_prio);
    next_s.core_vec = p_idx;
    next_s.evt      = (s.evt & ~ev_clr) | ev;
    next_s.irq_out  = |(next_s.evt & next_s.evt_mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign core_irq = s.core_irq;
  assign core_vec = s.core_vec;
  assign irq_out  = s.irq_out;

  //--------------------------------------------------------------------
  // assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_to(logic [7:0] ofs);
    do_wr && s.awaddr == ofs;
  endsequence

  sequence s_ret_level3;
    (core_ret && a_found && a_idx == 5'h03)
      ##1 (irq_req[3] && s.enable[3]);
  endsequence

  a_pset_sets: assert property (
    s_wr_to(`IPPC_OFS_PSET) and (s.wdata[0] && s.wstrb[0])
      |=> s.pending[0])
    else $error("pending set write did not pend source 0");

  a_pclr_clears: assert property (
    s_wr_to(`IPPC_OFS_PCLR) and (s.wdata[5] && s.wstrb[0] && !hw_set[5])
      |=> !s.pending[5])
    else $error("pending clear write left source 5 pending");

  a_zero_keeps: assert property (
    s_wr_to(`IPPC_OFS_PSET) and (s.wdata == 32'h0 && hw_set == 32'h0
      && ack_oh == 32'h0) |=> s.pending == $past(s.pending))
    else $error("zero write changed pending state");

  a_read_pend: assert property (
    rd_take && (araddr == `IPPC_OFS_PSET || araddr == `IPPC_OFS_PCLR)
      |=> rvalid && rdata == $past(s.pending) && rresp == `IPPC_RESP_OKAY)
    else $error("pending read returned wrong data");

  a_prio_zero_bits: assert property (
    rvalid && s.rd_prio |-> (rdata & `IPPC_RO_ZERO_MASK) == 32'h0)
    else $error("priority select low bits not zero");

  a_eff_prio: assert property (
    p_found |-> p_prio == {3'h0, p_idx}
      + 8'({sel_flat[p_idx*2 +: 2], 6'h00}))
    else $error("effective priority mismatch");

  a_prio_no_err: assert property (
    s_wr_to(`IPPC_OFS_PRIO_LO) |=> bvalid && bresp == `IPPC_RESP_OKAY)
    else $error("priority select write answered with error");

  a_level_repend: assert property (
    s_ret_level3 |=> s.pending[3])
    else $error("level request not re-pended after return");

  a_edge_pend: assert property (
    s.enable[4] && irq_req[4] && !s.req_q[4] |=> s.pending[4])
    else $error("rising edge did not pend source 4");

  a_fwd_enabled: assert property (
    core_irq |-> (($past(s.pending & s.enable) >> core_vec) & 32'h1)
      != 32'h0)
    else $error("request forwarded for a disabled source");

  a_nest_better: assert property (
    core_irq |-> !$past(a_found) || $past(p_prio) < $past(a_prio))
    else $error("request raised without better priority");

endmodule // ippc_top

// ===== rtl/ippc_defines.svh
// ippc_defines.svh: offsets, field positions, reset values and codes
// assumes: included by the package and the design files by bare name
`ifndef IPPC_DEFINES_SVH
`define IPPC_DEFINES_SVH

//----------------------------------------------------------------------
// register map (byte addresses)
//----------------------------------------------------------------------
`define IPPC_ADDR_W       8
`define IPPC_OFS_ENABLE   8'h10
`define IPPC_OFS_PSET     8'h18
`define IPPC_OFS_PCLR     8'h1C
`define IPPC_OFS_PRIO_LO  8'h40
`define IPPC_OFS_PRIO_HI  8'h5C
`define IPPC_OFS_EVT_STAT 8'h64
`define IPPC_OFS_EVT_MASK 8'h68

//----------------------------------------------------------------------
// fields, reset values, codes
//----------------------------------------------------------------------
`define IPPC_NSRC         32
`define IPPC_PRIO_WORDS   8
`define IPPC_SEL_HI       7
`define IPPC_SEL_LO       6
`define IPPC_PRIO_STEP    8'h40
`define IPPC_RO_ZERO_MASK 32'h3F3F3F3F
`define IPPC_EVT_W        2
`define IPPC_EVT_PEND     0
`define IPPC_EVT_NEST     1
`define IPPC_RST_WORD     32'h00000000
`define IPPC_RST_EVT      2'h0
`define IPPC_RESP_OKAY    2'h0
`define IPPC_RESP_SLVERR  2'h2

`endif

// ===== rtl/ippc_pkg.sv
// ippc_pkg: types and shared functions of the pending/priority block
// assumes: ippc_defines.svh on the include path
`include "ippc_defines.svh"

package ippc_pkg;

  //--------------------------------------------------------------------
  // bus channel states
  //--------------------------------------------------------------------
  typedef enum logic [0:0] {WS_IDLE = 1'b0, WS_RESP = 1'b1} ippc_wr_st_t;
  typedef enum logic [0:0] {RS_IDLE = 1'b0, RS_DATA = 1'b1} ippc_rd_st_t;

  //--------------------------------------------------------------------
  // state of the top module and the priority storage
  //--------------------------------------------------------------------
  typedef struct packed {
    ippc_wr_st_t           wr_st;
    logic                  aw_got;
    logic                  w_got;
    logic [7:0]            awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic [1:0]            bresp;
    ippc_rd_st_t           rd_st;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  rd_prio;
    logic [31:0]           enable;
    logic [31:0]           pending;
    logic [31:0]           active;
    logic [31:0]           req_q;
    logic [1:0]            evt;
    logic [1:0]            evt_mask;
    logic                  irq_out;
    logic                  core_irq;
    logic [4:0]            core_vec;
  } ippc_state_t;

  typedef struct packed {
    logic [7:0][7:0]       word;
    logic [31:0]           rdata;
  } ippc_mem_state_t;

  //--------------------------------------------------------------------
  // shared functions
  //--------------------------------------------------------------------
  function automatic logic [7:0] eff_prio(input logic [4:0] idx,
                                          input logic [1:0] sel);
    eff_prio = {3'h0, idx} + 8'({sel, 6'h00});
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic is_prio(input logic [7:0] a);
    is_prio = (a >= `IPPC_OFS_PRIO_LO) && (a <= `IPPC_OFS_PRIO_HI);
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `IPPC_OFS_ENABLE) || (a == `IPPC_OFS_PSET)
           || (a == `IPPC_OFS_PCLR) || (a == `IPPC_OFS_EVT_STAT)
           || (a == `IPPC_OFS_EVT_MASK) || is_prio(a);
  endfunction

endpackage

// ===== rtl/ippc_prio_mem.sv
// ippc_prio_mem: 32 two-bit priority select fields, four to a word
// assumes: byte lane b of word w holds the field of source 4*w+b
`include "ippc_defines.svh"

module ippc_prio_mem (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write port
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_idx,
  input  wire logic [3:0]  wr_strb,
  input  wire logic [31:0] wr_data,
  // read port
  input  wire logic        rd_en,
  input  wire logic [2:0]  rd_idx,
  output      logic [31:0] rd_data,
  // all fields for arbitration
  output      logic [63:0] sel_flat
);

  ippc_pkg::ippc_mem_state_t s;
  ippc_pkg::ippc_mem_state_t next_s;

  //--------------------------------------------------------------------
  // storage: only bits 7:6 of each byte kept, the rest read zero
  //--------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    if (wr_en)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wr_strb[b])
        begin
          next_s.word[wr_idx][b*2 +: 2] =
            wr_data[b*8+`IPPC_SEL_LO +: 2];
        end
      end
    end
    if (rd_en)
    begin
      for (int b = 0; b < 4; b++)
      begin
        next_s.rdata[b*8 +: 8] = {s.word[rd_idx][b*2 +: 2], 6'h00};
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rd_data = s.rdata;

  // one field per source, 32 in all
  always_comb
  begin
    for (int i = 0; i < `IPPC_NSRC; i++)
    begin
      sel_flat[i*2 +: 2] = s.word[i/4][(i%4)*2 +: 2];
    end
  end

endmodule // ippc_prio_mem

// ===== rtl/ippc_arbiter.sv
// ippc_arbiter: picks the candidate with the lowest effective priority
// assumes: stateless; sel_flat holds two bits per source
`include "ippc_defines.svh"

module ippc_arbiter (
  // candidates
  input  wire logic [31:0] cand,
  input  wire logic [63:0] sel_flat,
  // winner
  output      logic        found,
  output      logic [4:0]  idx,
  output      logic [7:0]  prio
);

  logic [7:0] p;

  always_comb
  begin
    found = 1'b0;
    idx   = 5'h00;
    prio  = 8'hFF;
    p     = 8'h00;
    for (int i = 0; i < `IPPC_NSRC; i++)
    begin
      p = ippc_pkg::eff_prio(5'(i), sel_flat[i*2 +: 2]);
      // strict compare keeps the lower index on a tie
      if (cand[i] && (!found || p < prio))
      begin
        found = 1'b1;
        idx   = 5'(i);
        prio  = p;
      end
    end
  end

endmodule // ippc_arbiter

// ===== dv/ippc_core_model.sv
// ippc_core_model: processor core that enters and leaves routines
// assumes: one aclk domain; enter_en and ret_req come from the bench
module ippc_core_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // block side
  input  wire logic       core_irq,
  input  wire logic [4:0] core_vec,
  output      logic       core_ack,
  output      logic       core_ret,
  // bench control
  input  wire logic       enter_en,
  input  wire logic       ret_req,
  output      logic [4:0] last_vec,
  output      int         acks
);
  timeunit 1ns;
  timeprecision 1ps;
  int holdoff;

  // holdoff rides out the registered lag of core_irq after an entry
  always_ff @(posedge aclk)
  begin
    core_ack <= 1'b0;
    core_ret <= ret_req;
    if (!aresetn)
    begin
      core_ret <= 1'b0;
      last_vec <= 5'h00;
      acks     <= 0;
      holdoff  <= 0;
    end
    else if (holdoff > 0)
      holdoff <= holdoff - 1;
    else if (enter_en && core_irq)
    begin
      core_ack <= 1'b1;
      last_vec <= core_vec;
      acks     <= acks + 1;
      holdoff  <= 3;
    end
  end
endmodule // ippc_core_model

// ===== dv/testbench.sv
// testbench: self-checking bench of the pending/priority block
// assumes: ippc_top and ippc_core_model compiled before it
`include "ippc_defines.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        core_irq, core_ack, core_ret, irq_out, enter_en, ret_req;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, irq_req, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [4:0]  core_vec, last_vec;
  int          acks, err_total, num_checks;

  ippc_top i_ippc_top (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
    .rdata, .rresp, .irq_req, .core_irq, .core_vec, .core_ack, .core_ret,
    .irq_out);

  ippc_core_model i_ippc_core_model (.aclk, .aresetn, .core_irq,
    .core_vec, .core_ack, .core_ret, .enter_en, .ret_req, .last_vec,
    .acks);

  //--------------------------------------------------------------------
  // shared tasks
  //--------------------------------------------------------------------
  task automatic report_and_stop();
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 50);
    rsp = bresp;
    bready <= 1'b0;
    if (n >= 50) err_total++;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 50);
    rd  = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (n >= 50) err_total++;
  endtask

  task automatic pulse(input int s);
    @(posedge aclk);
    irq_req[s] <= 1'b1;
    @(posedge aclk);
    irq_req[s] <= 1'b0;
  endtask

  task automatic leave();
    @(posedge aclk);
    ret_req <= 1'b1;
    @(posedge aclk);
    ret_req <= 1'b0;
  endtask

  task automatic wait_ack(input int n);
    for (int i = 0; i < 60 && acks < n; i++) @(posedge aclk);
    chk(32'(acks), 32'(n));
  endtask

  //--------------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------------
  task automatic t_reset();
    rd_reg(`IPPC_OFS_PSET);
    chk(rd, 32'h0);
    rd_reg(`IPPC_OFS_PCLR);
    chk(rd, 32'h0);
    for (int w = 0; w < 8; w++)
    begin
      rd_reg(8'h40 + 8'(4 * w));
      chk(rd, 32'h0);
    end
  endtask

  task automatic t_pend();
    wr(`IPPC_OFS_PSET, 32'h80000001);
    rd_reg(`IPPC_OFS_PSET);
    chk(rd, 32'h80000001);
    rd_reg(`IPPC_OFS_PCLR);
    chk(rd, 32'h80000001);
    wr(`IPPC_OFS_PSET, 32'h0);
    rd_reg(`IPPC_OFS_PSET);
    chk(rd, 32'h80000001);
    wr(`IPPC_OFS_PCLR, 32'h1);
    rd_reg(`IPPC_OFS_PSET);
    chk(rd, 32'h80000000);
    wr(`IPPC_OFS_PCLR, 32'h0);
    rd_reg(`IPPC_OFS_PCLR);
    chk(rd, 32'h80000000);
    wr(`IPPC_OFS_PCLR, 32'hFFFFFFFF);
    rd_reg(`IPPC_OFS_PSET);
    chk(rd, 32'h0);
  endtask

  task automatic t_prio();
    for (int w = 0; w < 8; w++)
    begin
      wr(8'h40 + 8'(4 * w), 32'hFF7FBF3F);
      chk(32'(rsp), 32'h0);
      rd_reg(8'h40 + 8'(4 * w));
      chk(rd, 32'hC0408000);
      wr(8'h40 + 8'(4 * w), 32'h0);
    end
    wr(8'h20, 32'hFFFFFFFF);
    chk(32'(rsp), 32'h2);
    rd_reg(8'h20);
    chk(32'(rsp), 32'h2);
  endtask

  task automatic t_arb();
    wr(`IPPC_OFS_ENABLE, 32'hFFFFFFFF);
    wr(`IPPC_OFS_PSET, 32'h00000024);
    cyc(4);
    chk(32'(core_irq), 32'h1);
    chk(32'(core_vec), 32'h2);
    wr(`IPPC_OFS_PCLR, 32'hFFFFFFFF);
    wr(`IPPC_OFS_PSET, 32'h80000002);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h40, {16'h0, 2'(s), 14'h0});
      wr(8'h5C, {2'(s > 0 ? s - 1 : 0), 30'h0});
      cyc(4);
      chk(32'(core_vec), s > 0 ? 32'h1F : 32'h1);
      wr(8'h5C, {2'(s), 30'h0});
      cyc(4);
      chk(32'(core_vec), 32'h1);
    end
    wr(8'h40, 32'h0);
    wr(8'h5C, 32'h0);
    wr(`IPPC_OFS_PCLR, 32'hFFFFFFFF);
  endtask

  task automatic t_event();
    wr(`IPPC_OFS_EVT_STAT, 32'h3);
    wr(`IPPC_OFS_EVT_MASK, 32'h0);
    pulse(7);
    cyc(4);
    chk(32'(irq_out), 32'h0);
    rd_reg(`IPPC_OFS_EVT_STAT);
    chk(rd, 32'h1);
    wr(`IPPC_OFS_EVT_MASK, 32'h1);
    cyc(3);
    chk(32'(irq_out), 32'h1);
    wr(`IPPC_OFS_EVT_STAT, 32'h1);
    cyc(3);
    chk(32'(irq_out), 32'h0);
    wr(`IPPC_OFS_PCLR, 32'hFFFFFFFF);
  endtask

  task automatic t_service();
    wr(`IPPC_OFS_ENABLE, 32'h0);
    @(posedge aclk);
    irq_req[3] <= 1'b1;
    cyc(4);
    rd_reg(`IPPC_OFS_PSET);
    chk(rd, 32'h0);
    wr(`IPPC_OFS_ENABLE, 32'hFFFFFFFF);
    cyc(4);
    rd_reg(`IPPC_OFS_PSET);
    chk(rd, 32'h8);
    chk(32'(core_vec), 32'h3);
    enter_en <= 1'b1;
    wait_ack(1);
    cyc(4);
    rd_reg(`IPPC_OFS_PSET);
    chk(rd, 32'h0);
    leave();
    wait_ack(2);
    irq_req[3] <= 1'b0;
    leave();
    cyc(8);
    chk(32'(acks), 32'h2);
    pulse(10);
    wait_ack(3);
    chk(32'(last_vec), 32'hA);
    pulse(20);
    cyc(6);
    chk(32'(acks), 32'h3);
    rd_reg(`IPPC_OFS_PSET);
    chk(rd, 32'h00100000);
    pulse(4);
    wait_ack(4);
    chk(32'(last_vec), 32'h4);
    rd_reg(`IPPC_OFS_EVT_STAT);
    chk(rd & 32'h2, 32'h2);
    leave();
    cyc(6);
    chk(32'(acks), 32'h4);
    leave();
    wait_ack(5);
    chk(32'(last_vec), 32'h14);
    leave();
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial
  begin
    #200us;
    err_total++;
    report_and_stop();
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {enter_en, ret_req, awaddr, araddr, wdata, irq_req} = '0;
    wstrb      = 4'hF;
    err_total  = 0;
    num_checks = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_pend();
    t_prio();
    t_arb();
    t_event();
    t_service();
    report_and_stop();
  end
endmodule // testbench
